// [tsc_i2c_slave_port.sv]
// Purpose: two-wire serial slave port of a touch slider controller
// Assumes: pin inputs synchronous to mclk; bus far slower than mclk
// Notes:   open-drain bus pins: oe high pulls the wire low
`timescale 1ns/1ps

module tsc_i2c_slave_port (
   input  wire logic                       mclk,
   input  wire logic                       srst,
   input  wire logic                       external_reset_in,
   input  wire logic                       setup_mode,
   input  wire logic                       scl_in,
   output logic                            scl_out,
   output logic                            scl_oe,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe,
   input  wire logic [tsc_pkg::PORT_W-1:0] first_general_port_in,
   output logic [tsc_pkg::PORT_W-1:0]      first_general_port_out,
   output logic [tsc_pkg::PORT_W-1:0]      first_general_port_oe,
   input  wire logic [tsc_pkg::PORT_W-1:0] second_general_port_in,
   output logic [tsc_pkg::PORT_W-1:0]      second_general_port_out,
   output logic [tsc_pkg::PORT_W-1:0]      second_general_port_oe,
   output logic [2*tsc_pkg::PORT_W-1:0]    sense_enable
);
   tsc_pkg::tsc_core_s r;
   tsc_pkg::tsc_core_s next_r;

   logic       rst;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic       wr_ok;
   logic       mem_we;
   logic [7:0] rd_byte;
   logic [7:0] stretch_len;
   logic [9:0] pin_out;
   logic [9:0] pin_oe;

   tsc_mem_if #(.AW(7), .DW(8)) mem_bus ();

   tsc_regmem #(.AW(7), .DW(8)) u_regmem (
      .mclk (mclk),
      .port (mem_bus.mem)
   );

   assign rst = srst | external_reset_in;

   assign mem_bus.addr  = r.ptr;
   assign mem_bus.we    = mem_we;
   assign mem_bus.wdata = r.shreg;

   assign scl_rise   = scl_in & ~r.scl_q;
   assign scl_fall   = ~scl_in & r.scl_q;
   assign start_seen = scl_in & r.scl_q & r.sda_q & ~sda_in;
   assign stop_seen  = scl_in & r.scl_q & ~r.sda_q & sda_in;

   // input ports read live pin levels, everything else the store
   always_comb begin
      if (r.ptr == tsc_pkg::REG_IN0) begin
         rd_byte = {3'h0, first_general_port_in};
      end else if (r.ptr == tsc_pkg::REG_IN1) begin
         rd_byte = {3'h0, second_general_port_in};
      end else begin
         rd_byte = mem_bus.rdata;
      end
   end

   // same delay whatever the configuration, longer only in setup
   assign stretch_len = setup_mode ? tsc_pkg::STRETCH_SETUP
                                   : tsc_pkg::STRETCH_NORM;

   assign wr_ok = (r.ptr > tsc_pkg::REG_LAST_RO) &&
                  (setup_mode || !tsc_pkg::setup_only(r.ptr));

   always_comb begin
      next_r = r;
      mem_we = 1'b0;
      next_r.scl_q = scl_in;
      next_r.sda_q = sda_in;
      if (r.pwr != 12'h000) begin
         next_r.pwr = r.pwr - 12'h001;
      end
      if (start_seen) begin
         next_r.st       = tsc_pkg::ST_RX;
         next_r.bitcnt   = 4'h0;
         next_r.is_addr  = 1'b1;
         next_r.is_index = 1'b0;
         next_r.sda_oe   = 1'b0;
         next_r.scl_oe   = 1'b0;
      end else if (stop_seen) begin
         next_r.st     = tsc_pkg::ST_IDLE;
         next_r.sda_oe = 1'b0;
         next_r.scl_oe = 1'b0;
      end else begin
         unique case (r.st)
            tsc_pkg::ST_IDLE: begin
            end
            tsc_pkg::ST_RX: begin
               if (scl_rise) begin
                  next_r.shreg  = {r.shreg[6:0], sda_in};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == 4'h8) begin
                  next_r.st     = tsc_pkg::ST_STRETCH;
                  next_r.scl_oe = 1'b1;
                  next_r.cnt    = stretch_len;
               end
            end
            tsc_pkg::ST_STRETCH: begin
               if (r.cnt != 8'h00) begin
                  next_r.cnt = r.cnt - 8'h01;
               end else if (r.is_addr) begin
                  next_r.is_addr = 1'b0;
                  if (r.shreg[7:1] == r.own_addr) begin
                     next_r.rw       = r.shreg[tsc_pkg::RW_BIT];
                     next_r.is_index = ~r.shreg[tsc_pkg::RW_BIT];
                     next_r.sda_oe   = 1'b1;
                     next_r.st       = tsc_pkg::ST_ACK;
                  end else begin
                     next_r.st     = tsc_pkg::ST_SKIP;
                     next_r.scl_oe = 1'b0;
                  end
               end else if (r.is_index) begin
                  next_r.ptr      = r.shreg[6:0];
                  next_r.is_index = 1'b0;
                  next_r.sda_oe   = 1'b1;
                  next_r.st       = tsc_pkg::ST_ACK;
               end else begin
                  // blocked writes still get their acknowledge
                  if (wr_ok) begin
                     mem_we = 1'b1;
                     unique case (r.ptr)
                        tsc_pkg::REG_OUT0:  next_r.outv[4:0] = r.shreg[4:0];
                        tsc_pkg::REG_OUT1:  next_r.outv[9:5] = r.shreg[4:0];
                        tsc_pkg::REG_CSEN0: next_r.csen[4:0] = r.shreg[4:0];
                        tsc_pkg::REG_CSEN1: next_r.csen[9:5] = r.shreg[4:0];
                        tsc_pkg::REG_GPEN0: next_r.gpen[4:0] = r.shreg[4:0];
                        tsc_pkg::REG_GPEN1: next_r.gpen[9:5] = r.shreg[4:0];
                        tsc_pkg::REG_BUS_ADDR:
                           next_r.own_addr = r.shreg[6:0];
                        default: begin
                        end
                     endcase
                  end
                  next_r.ptr    = r.ptr + 7'h01;
                  next_r.sda_oe = 1'b1;
                  next_r.st     = tsc_pkg::ST_ACK;
               end
            end
            tsc_pkg::ST_ACK: begin
               // acknowledge is set up a cycle before the clock is let go
               if (r.scl_oe) begin
                  next_r.scl_oe = 1'b0;
               end else if (scl_fall) begin
                  next_r.bitcnt = 4'h0;
                  if (r.rw) begin
                     next_r.st     = tsc_pkg::ST_TX;
                     next_r.sda_oe = ~rd_byte[7];
                     next_r.shreg  = {rd_byte[6:0], 1'b0};
                     next_r.bitcnt = 4'h1;
                  end else begin
                     next_r.st     = tsc_pkg::ST_RX;
                     next_r.sda_oe = 1'b0;
                  end
               end
            end
            tsc_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r.bitcnt == 4'h8) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st     = tsc_pkg::ST_MACK;
                  end else begin
                     next_r.sda_oe = ~r.shreg[7];
                     next_r.shreg  = {r.shreg[6:0], 1'b0};
                     next_r.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end
            tsc_pkg::ST_MACK: begin
               if (scl_rise) begin
                  next_r.acked = ~sda_in;
                  if (!sda_in) begin
                     next_r.ptr = r.ptr + 7'h01;
                  end
               end else if (scl_fall) begin
                  if (r.acked) begin
                     next_r.st     = tsc_pkg::ST_TX;
                     next_r.sda_oe = ~rd_byte[7];
                     next_r.shreg  = {rd_byte[6:0], 1'b0};
                     next_r.bitcnt = 4'h1;
                  end else begin
                     next_r.st = tsc_pkg::ST_SKIP;
                  end
               end
            end
            tsc_pkg::ST_SKIP: begin
            end
            default: begin
               next_r.st     = tsc_pkg::ST_IDLE;
               next_r.sda_oe = 1'b0;
               next_r.scl_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= tsc_pkg::CORE_RST;
      end else begin
         r <= next_r;
      end
   end

   // per pin: sensing wins over general I/O when both are enabled, except pins 6 and 7, which are driven while the power-up count runs
   for (genvar i = 0; i < 10; i++) begin : g_pin
      if (i == 6 || i == 7) begin : g_factory
         assign pin_oe[i]  = (r.pwr != 12'h000) ? 1'b1
                           : (r.gpen[i] & ~r.csen[i]);
         assign pin_out[i] = (r.pwr != 12'h000)
                           ? r.pwr[tsc_pkg::TOGGLE_BIT] : r.outv[i];
      end else begin : g_plain
         assign pin_oe[i]  = r.gpen[i] & ~r.csen[i];
         assign pin_out[i] = r.outv[i];
      end
      assign sense_enable[i] = r.csen[i];
   end

   assign first_general_port_out  = pin_out[4:0];
   assign first_general_port_oe   = pin_oe[4:0];
   assign second_general_port_out = pin_out[9:5];
   assign second_general_port_oe  = pin_oe[9:5];

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = r.scl_oe;
   assign sda_oe  = r.sda_oe;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   logic in_stretch;
   assign in_stretch = (r.st == tsc_pkg::ST_STRETCH);

   sequence s_enter_stretch;
      $rose(in_stretch);
   endsequence

   sequence s_leave_norm;
      ##[19:21] !in_stretch;
   endsequence

   sequence s_leave_setup;
      ##[99:101] !in_stretch;
   endsequence

   a_stretch_hold: assert property (
      s_enter_stretch |-> (in_stretch && scl_oe) [*8])
      else $error("clock released too early after byte");

   a_norm_delay: assert property (
      s_enter_stretch and !setup_mode |-> s_leave_norm)
      else $error("normal acknowledge delay wrong");

   a_setup_delay: assert property (
      s_enter_stretch and setup_mode and $past(setup_mode)
      |-> s_leave_setup)
      else $error("setup acknowledge delay wrong");

   a_protect_write: assert property (
      mem_we && !setup_mode |-> !tsc_pkg::setup_only(r.ptr))
      else $error("setup-only register written in normal mode");

   a_blocked_ack: assert property (
      in_stretch && r.cnt == 8'h00 && !r.is_addr && !r.is_index
      && !wr_ok |-> !mem_we ##1 (r.st == tsc_pkg::ST_ACK && sda_oe))
      else $error("blocked write not acknowledged or stored");

   a_foreign_idle: assert property (
      r.st == tsc_pkg::ST_SKIP |-> !sda_oe && !scl_oe)
      else $error("bus touched for foreign address");

   a_addr_match: assert property (
      in_stretch && r.cnt == 8'h00 && r.is_addr
      |=> (r.st == tsc_pkg::ST_ACK) == ($past(r.shreg[7:1]) ==
                                        $past(r.own_addr)))
      else $error("address match decision wrong");

   a_addr_update: assert property (
      mem_we && r.ptr == tsc_pkg::REG_BUS_ADDR
      |=> r.own_addr == $past(r.shreg[6:0]))
      else $error("bus address not reprogrammed");

   a_read_dir: assert property (
      r.st == tsc_pkg::ST_TX |-> r.rw)
      else $error("data sent on a write transfer");

   a_pin_mode: assert property (
      r.pwr == 12'h000 |-> first_general_port_oe ==
                           (r.gpen[4:0] & ~r.csen[4:0]))
      else $error("pin mode not from configuration");

   a_factory_toggle: assert property (
      r.pwr != 12'h000 |-> second_general_port_oe[2:1] == 2'b11)
      else $error("factory pins not driven at power-up");

endmodule

// [tsc_pkg.sv]
// Purpose: shared constants, types and state layout of the touch slave port
// Assumes: mclk at 20 MHz (50 ns)
// Notes:   register indices are 7-bit; pointer wraps at 0x7f
package tsc_pkg;

   localparam int unsigned CLK_NS       = 50;
   localparam int unsigned ACK_NORM_NS  = 1000;
   localparam int unsigned ACK_SETUP_NS = 5000;
   localparam int unsigned PWRUP_NS     = 100000;
   // least times: round up to whole cycles
   localparam int unsigned ACK_NORM_CYC  = (ACK_NORM_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ACK_SETUP_CYC = (ACK_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned PWRUP_CYC     = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TOGGLE_BIT    = 7;

   localparam logic [7:0]  STRETCH_NORM  = 8'(ACK_NORM_CYC - 1);
   localparam logic [7:0]  STRETCH_SETUP = 8'(ACK_SETUP_CYC - 1);
   localparam logic [11:0] PWRUP_LOAD    = 12'(PWRUP_CYC);

   localparam int unsigned RW_BIT      = 0;
   localparam int unsigned PORT_W      = 5;
   localparam logic [6:0]  DEF_BUS_ADDR = 7'h01;

   localparam logic [6:0] REG_IN0      = 7'h00;
   localparam logic [6:0] REG_IN1      = 7'h01;
   localparam logic [6:0] REG_LAST_RO  = 7'h03;
   localparam logic [6:0] REG_OUT0     = 7'h04;
   localparam logic [6:0] REG_OUT1     = 7'h05;
   localparam logic [6:0] REG_CSEN0    = 7'h06;
   localparam logic [6:0] REG_CSEN1    = 7'h07;
   localparam logic [6:0] REG_GPEN0    = 7'h08;
   localparam logic [6:0] REG_GPEN1    = 7'h09;
   localparam logic [6:0] REG_BUS_ADDR = 7'h7c;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_RX      = 7'h02,
      ST_STRETCH = 7'h04,
      ST_ACK     = 7'h08,
      ST_TX      = 7'h10,
      ST_MACK    = 7'h20,
      ST_SKIP    = 7'h40
   } tsc_state_e;

   typedef struct packed {
      tsc_state_e  st;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic        is_addr;
      logic        is_index;
      logic        rw;
      logic        acked;
      logic [6:0]  ptr;
      logic [7:0]  cnt;
      logic        scl_oe;
      logic        sda_oe;
      logic        scl_q;
      logic        sda_q;
      logic [6:0]  own_addr;
      logic [9:0]  outv;
      logic [9:0]  csen;
      logic [9:0]  gpen;
      logic [11:0] pwr;
   } tsc_core_s;

   localparam tsc_core_s CORE_RST = '{
      st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, is_addr: 1'b0,
      is_index: 1'b0, rw: 1'b0, acked: 1'b0, ptr: 7'h00, cnt: 8'h00,
      scl_oe: 1'b0, sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
      own_addr: DEF_BUS_ADDR, outv: 10'h000, csen: 10'h000,
      gpen: 10'h000, pwr: PWRUP_LOAD};

   // registers that accept writes only in setup mode
   function automatic logic setup_only(input logic [6:0] idx);
      return (idx >= 7'h06 && idx <= 7'h09) || idx == 7'h0c ||
             idx == 7'h0d || (idx >= 7'h10 && idx <= 7'h17) ||
             idx == 7'h50 || idx == 7'h51 ||
             (idx >= 7'h57 && idx <= 7'h60) || idx == 7'h7e;
   endfunction

endpackage

// [tsc_mem_if.sv]
// Purpose: port between the serial engine and its register store
// Assumes: single port, one read every cycle plus at most one write
// Notes:   rdata follows addr one cycle later
`timescale 1ns/1ps
interface tsc_mem_if #(
   parameter int AW = 7,
   parameter int DW = 8
);
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctl (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [tsc_regmem.sv]
// Purpose: register store of the touch controller configuration space
// Assumes: contents undefined after power-up, as the store is data only
// Notes:   read data registered
`timescale 1ns/1ps
module tsc_regmem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic mclk,
   tsc_mem_if.mem   port
);
   logic [DW-1:0] store [2**AW];
   logic [DW-1:0] rdata;

   always_ff @(posedge mclk) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
      rdata <= store[port.addr];
   end

   assign port.rdata = rdata;
endmodule

// [tsc_bus_master.sv]
// Purpose: two-wire bus master model facing the touch slave port
// Assumes: open-drain wires with pull-ups; changes after mclk falls
// Notes:   waits out any clock hold by the slave, up to a bound
`timescale 1ns/1ps
module tsc_bus_master #(
   parameter int HALF = 10
) (
   input  wire logic mclk,
   input  wire logic scl_line,
   input  wire logic sda_line,
   output logic      scl_low,
   output logic      sda_low
);
   int stalls;

   // only ever pulls a wire low, never drives it high
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      stalls  = 0;
   end

   task automatic gap(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // release the clock and wait while the slave still holds it
   task automatic rise_scl();
      int k;
      k = 0;
      scl_low = 1'b0;
      @(negedge mclk);
      while (scl_line !== 1'b1 && k < 4000) begin
         @(negedge mclk);
         k++;
      end
      // bound far above the longest hold, so a fixed wait would also fit
      if (k >= 4000) begin
         stalls++;
      end
   endtask

   task automatic start();
      // no sleep mode is ever enabled, so no wake pulse is needed
      sda_low = 1'b0;
      gap(HALF);
      rise_scl();
      gap(HALF);
      sda_low = 1'b1;
      gap(HALF);
      scl_low = 1'b1;
   endtask

   task automatic stop();
      gap(2);
      sda_low = 1'b1;
      gap(HALF);
      rise_scl();
      gap(HALF);
      sda_low = 1'b0;
      gap(HALF);
   endtask

   // data moves a few cycles after the clock falls, never with it
   task automatic bit_out(input logic b);
      gap(2);
      sda_low = ~b;
      gap(HALF);
      rise_scl();
      gap(HALF);
      scl_low = 1'b1;
   endtask

   task automatic bit_in(output logic v);
      gap(2);
      sda_low = 1'b0;
      gap(HALF);
      rise_scl();
      gap(HALF);
      v = sda_line;
      scl_low = 1'b1;
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i]);
      end
      bit_in(v);
      ack = ~v;
   endtask

   task automatic recv_byte(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--) begin
         bit_in(b[i]);
      end
      bit_out(last);
   endtask
endmodule

// [tb.sv]
// Purpose: self-checking bench of the touch slave port
// Assumes: 20 MHz mclk; bus wires resolved here with pull-ups
// Notes:   register store starts unknown, so reads follow writes
`timescale 1ns/1ps
module tb;
   logic                       mclk;
   logic                       srst;
   logic                       external_reset_in;
   logic                       setup_mode;
   logic                       scl_out;
   logic                       scl_oe;
   logic                       sda_out;
   logic                       sda_oe;
   logic                       m_scl_low;
   logic                       m_sda_low;
   logic                       scl_line;
   logic                       sda_line;
   logic [tsc_pkg::PORT_W-1:0] first_in;
   logic [tsc_pkg::PORT_W-1:0] first_out;
   logic [tsc_pkg::PORT_W-1:0] first_oe;
   logic [tsc_pkg::PORT_W-1:0] second_in;
   logic [tsc_pkg::PORT_W-1:0] second_out;
   logic [tsc_pkg::PORT_W-1:0] second_oe;
   logic [9:0]                 sense_enable;
   int                         failures;
   int                         n_compared;
   int                         run_len  = 0;
   int                         last_run = 0;
   logic                       sda_seen = 1'b0;

   assign scl_line = ~(scl_oe | m_scl_low);
   assign sda_line = ~(sda_oe | m_sda_low);

   tsc_i2c_slave_port i_tsc_i2c_slave_port (
      .mclk                    (mclk),
      .srst                    (srst),
      .external_reset_in       (external_reset_in),
      .setup_mode              (setup_mode),
      .scl_in                  (scl_line),
      .scl_out                 (scl_out),
      .scl_oe                  (scl_oe),
      .sda_in                  (sda_line),
      .sda_out                 (sda_out),
      .sda_oe                  (sda_oe),
      .first_general_port_in   (first_in),
      .first_general_port_out  (first_out),
      .first_general_port_oe   (first_oe),
      .second_general_port_in  (second_in),
      .second_general_port_out (second_out),
      .second_general_port_oe  (second_oe),
      .sense_enable            (sense_enable)
   );

   tsc_bus_master i_tsc_bus_master (
      .mclk     (mclk),
      .scl_line (scl_line),
      .sda_line (sda_line),
      .scl_low  (m_scl_low),
      .sda_low  (m_sda_low)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // length of the latest clock hold by the slave
   always @(posedge mclk) begin
      if (scl_oe === 1'b1) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         last_run <= run_len;
         run_len  <= 0;
      end
      if (sda_oe === 1'b1) begin
         sda_seen <= 1'b1;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic st();
      i_tsc_bus_master.start();
   endtask
   task automatic sp();
      i_tsc_bus_master.stop();
   endtask
   task automatic tx(input logic [7:0] b, output logic ack);
      i_tsc_bus_master.send_byte(b, ack);
   endtask
   task automatic rx(output logic [7:0] b, input logic last);
      i_tsc_bus_master.recv_byte(b, last);
   endtask

   task automatic wr(input logic [6:0] a, input logic [6:0] idx,
                     input logic [7:0] d, output logic ok);
      logic k1, k2, k3;
      st();
      tx({a, 1'b0}, k1);
      tx({1'b0, idx}, k2);
      tx(d, k3);
      sp();
      ok = k1 & k2 & k3;
   endtask

   task automatic rd(input logic [6:0] a, input logic [6:0] idx,
                     output logic [7:0] d, output logic ok);
      logic k1, k2, k3;
      st();
      tx({a, 1'b0}, k1);
      tx({1'b0, idx}, k2);
      sp();
      st();
      tx({a, 1'b1}, k3);
      rx(d, 1'b1);
      sp();
      ok = k1 & k2 & k3;
   endtask

   task automatic t_powerup();
      logic a;
      check(scl_oe, 1'b0, "clock hold after reset");
      check(sda_oe, 1'b0, "data pull after reset");
      check(first_oe, 5'h00, "first port enables");
      check({scl_out, sda_out}, 2'b00, "open-drain levels");
      check(second_oe[2:1], 2'b11, "power-up pins driven");
      a = second_out[1];
      repeat (128) @(negedge mclk);
      check(second_out[1] ^ a, 1'b1, "power-up blink");
   endtask

   task automatic t_write_read();
      logic       k1, k2, k3, k4;
      logic [7:0] d0, d1;
      wr(7'h01, tsc_pkg::REG_OUT0, 8'h15, k1);
      check(k1, 1'b1, "write acknowledged");
      check(first_out, 5'h15, "output register");
      check(16'(last_run), 16'(tsc_pkg::ACK_NORM_CYC + 1), "hold");
      st();
      tx(8'h02, k1);
      tx(8'h0a, k2);
      tx(8'h5a, k3);
      tx(8'ha5, k4);
      sp();
      check({k1, k2, k3, k4}, 4'hf, "burst write acks");
      st();
      tx(8'h02, k1);
      tx(8'h0a, k2);
      sp();
      st();
      tx(8'h03, k3);
      rx(d0, 1'b0);
      rx(d1, 1'b1);
      sp();
      check({k1, k2, k3}, 3'h7, "read acks");
      check({d0, d1}, 16'h5aa5, "burst read");
      rd(7'h01, tsc_pkg::REG_IN0, d0, k1);
      check({k1, d0}, 9'h10d, "live pin read");
      rd(7'h01, tsc_pkg::REG_IN1, d1, k2);
      check({k2, d1}, 9'h112, "second port pins");
   endtask

   task automatic t_setup();
      logic [6:0] idx [9] = '{7'h0c, 7'h0d, 7'h10, 7'h17, 7'h50,
                              7'h51, 7'h57, 7'h60, 7'h7e};
      logic       k;
      logic [7:0] d;
      setup_mode = 1'b1;
      wr(7'h01, tsc_pkg::REG_CSEN0, 8'h01, k);
      wr(7'h01, tsc_pkg::REG_CSEN1, 8'h00, k);
      wr(7'h01, tsc_pkg::REG_GPEN1, 8'h00, k);
      wr(7'h01, tsc_pkg::REG_GPEN0, 8'h03, k);
      check(16'(last_run), 16'(tsc_pkg::ACK_SETUP_CYC + 1), "hold");
      foreach (idx[i]) begin
         wr(7'h01, idx[i], {1'b0, idx[i]}, k);
      end
      setup_mode = 1'b0;
      check(first_oe, 5'h02, "first port enables");
      check(second_oe, 5'h00, "second port enables");
      check(sense_enable, 10'h001, "sensing pins");
      wr(7'h01, tsc_pkg::REG_OUT1, 8'h1b, k);
      check({k, second_out}, 6'h3b, "second output register");
      wr(7'h01, tsc_pkg::REG_GPEN0, 8'h1f, k);
      check(k, 1'b1, "blocked write acknowledged");
      check(first_oe, 5'h02, "blocked write kept");
      foreach (idx[i]) begin
         wr(7'h01, idx[i], 8'hff, k);
         rd(7'h01, idx[i], d, k);
         check({k, d}, {2'b10, idx[i]}, "setup-only kept");
      end
   endtask

   task automatic t_foreign();
      logic k1, k2;
      sda_seen = 1'b0;
      st();
      tx({7'h22, 1'b0}, k1);
      tx(8'h04, k2);
      sp();
      check({k1, k2, sda_seen}, 3'h0, "foreign address ignored");
   endtask

   task automatic t_addr();
      logic       k1, k2;
      logic [7:0] d;
      wr(7'h01, tsc_pkg::REG_BUS_ADDR, 8'h2a, k1);
      wr(7'h01, 7'h0a, 8'h11, k2);
      check({k1, k2}, 2'b10, "old address dropped");
      wr(7'h2a, 7'h0a, 8'h11, k1);
      rd(7'h2a, 7'h0a, d, k2);
      check({k1, k2, d}, 10'h311, "new address");
      external_reset_in = 1'b1;
      repeat (2) @(negedge mclk);
      external_reset_in = 1'b0;
      @(negedge mclk);
      check(second_oe[2:1], 2'b11, "power-up pins again");
      rd(7'h01, 7'h0a, d, k1);
      check({k1, d}, 9'h111, "default address back");
   endtask

   // a hang must still reach the verdict
   initial begin
      repeat (100000) @(posedge mclk);
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
   end

   initial begin
      failures          = 0;
      n_compared        = 0;
      srst              = 1'b1;
      external_reset_in = 1'b0;
      setup_mode        = 1'b0;
      first_in          = 5'h0d;
      second_in         = 5'h12;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      @(negedge mclk);
      t_powerup();
      t_write_read();
      t_setup();
      t_foreign();
      t_addr();
      check(16'(i_tsc_bus_master.stalls), 16'h0000, "clock stuck");
      conclude();
   end
endmodule
